// ==== logic/rdp_map.vh ====
// rdp_map.vh: constants and behaviour notes for the realtime debug port
`ifndef RDP_MAP_VH
`define RDP_MAP_VH
// Notes on behaviour
// - each received frame carries its command code in bits 16 to 19
// - 000/100/101 monitor, 110 interrupt, 010 read, 011 write, 1111 recover
// - bit 19 is not stored; it only matters for recover
// - recover returns the port to normal work without system reset
// - read fetches RAM only in cycles the CPU leaves RAM free
// - RAM accesses are word aligned; two low address bits forced to zero
// - read data returns as one whole 32-bit word per output frame
// - the write happens in the third frame after the data frame, CPU-free cycles
// - write reads the word before and after writing, both sent back
// - monitor returns data at the address the CPU last touched
// - interrupt command raises the CPU request and returns monitor data
// - system reset leaves serial out and acknowledge high
// - acknowledge pulses low after a command; one period for monitor
// - ack width 1 monitor or irq, 2 read, 3 write or data, 4 recover
`define RDP_FRAME_MSB 31
`define RDP_LAST_BIT 5'h1f
`define RDP_CMD_LSB 16
`define RDP_CMD_MSB 18
`define RDP_RCV_BIT 19
`define RDP_ADDR_MSB 15
`define RDP_CMD_MON0 3'h0
`define RDP_CMD_MON1 3'h4
`define RDP_CMD_MON2 3'h5
`define RDP_CMD_IRQ 3'h6
`define RDP_CMD_READ 3'h2
`define RDP_CMD_WRITE 3'h3
`define RDP_CMD_ALL1 3'h7
`define RDP_RAM_LO 16'h4000
`define RDP_WORD_MASK 16'hfffc
`define RDP_ACK_NONE 3'h0
`define RDP_ACK_MON 3'h1
`define RDP_ACK_READ 3'h2
`define RDP_ACK_WRITE 3'h3
`define RDP_ACK_RCV 3'h4
`define RDP_WR_LAG 2'h1
`define RDP_RCV_ONES 7'h40
`define RDP_IDLE_WORD 32'hffffffff
`endif

// ==== logic/rdp_sync.v ====
// rdp_sync.v: two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module rdp_sync #(
    parameter W = 2
) (
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= {W{1'b1}};
            q <= {W{1'b1}};
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // rdp_sync

// ==== logic/rdp_ram_engine.v ====
// rdp_ram_engine.v: RAM access sequencer using CPU-free cycles
`timescale 1ns/1ps
module rdp_ram_engine (
    input wire clk,
    input wire rst_b,
    input wire clear,
    input wire start,
    input wire do_write,
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire cpu_next,
    input wire [31:0] ram_rdata,
    output reg ram_en,
    output reg ram_we,
    output reg [15:0] ram_addr,
    output reg [31:0] ram_wdata,
    output reg [31:0] pre_data,
    output reg [31:0] post_data,
    output reg done,
    output wire busy
);
    localparam S_IDLE = 3'h0;
    localparam S_RD1 = 3'h1;
    localparam S_W1 = 3'h2;
    localparam S_C1 = 3'h3;
    localparam S_WR = 3'h4;
    localparam S_RD2 = 3'h5;
    localparam S_W2 = 3'h6;
    localparam S_C2 = 3'h7;

    reg [2:0] state_reg;
    reg write_reg;

    assign busy = (state_reg != S_IDLE);

    // cpu_next warns one cycle ahead, so registered strobes never collide
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= S_IDLE;
            write_reg <= 1'b0;
            ram_en <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= 16'h0000;
            ram_wdata <= 32'h00000000;
            pre_data <= 32'h00000000;
            post_data <= 32'h00000000;
            done <= 1'b0;
        end
        else if (clear)
        begin
            state_reg <= S_IDLE;
            ram_en <= 1'b0;
            ram_we <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            ram_en <= 1'b0;
            ram_we <= 1'b0;
            done <= 1'b0;
            case (state_reg)
                S_IDLE:
                    if (start)
                    begin
                        ram_addr <= addr;
                        ram_wdata <= wdata;
                        write_reg <= do_write;
                        state_reg <= S_RD1;
                    end
                S_RD1, S_RD2:
                    if (!cpu_next)
                    begin
                        ram_en <= 1'b1;
                        state_reg <= (state_reg == S_RD1) ? S_W1 : S_W2;
                    end
                S_W1:
                    state_reg <= S_C1;
                S_W2:
                    state_reg <= S_C2;
                S_C1:
                begin
                    pre_data <= ram_rdata;
                    state_reg <= write_reg ? S_WR : S_IDLE;
                    done <= ~write_reg;
                end
                S_WR:
                    if (!cpu_next)
                    begin
                        ram_en <= 1'b1;
                        ram_we <= 1'b1;
                        state_reg <= S_RD2;
                    end
                S_C2:
                begin
                    post_data <= ram_rdata;
                    state_reg <= S_IDLE;
                    done <= 1'b1;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // rdp_ram_engine

// ==== logic/rdp_top.v ====
// rdp_top.v: serial realtime debug port with dedicated RAM path
`timescale 1ns/1ps
`include "rdp_map.vh"
module rdp_top (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // serial link from the debug host
    input wire DBG_SHIFT_CLOCK,
    input wire DBG_SERIAL_IN,
    output reg DBG_SERIAL_OUT,
    output reg DBG_ACK_PULSE,
    // interrupt request to the CPU
    output reg DBG_IRQ,
    // CPU activity tap
    input wire CPU_RAM_NEXT,
    input wire CPU_ACC_VALID,
    input wire [15:0] CPU_ACC_ADDR,
    // dedicated RAM port
    output wire RAM_EN,
    output wire RAM_WE,
    output wire [15:0] RAM_ADDR,
    output wire [31:0] RAM_WDATA,
    input wire [31:0] RAM_RDATA
);
    // ack width in shift clock periods for a received command
    function [2:0] ack_width;
        input [2:0] cmd;
        input b19;
        begin
            case (cmd)
                `RDP_CMD_MON0, `RDP_CMD_MON1, `RDP_CMD_MON2, `RDP_CMD_IRQ:
                    ack_width = `RDP_ACK_MON;
                `RDP_CMD_READ:
                    ack_width = `RDP_ACK_READ;
                `RDP_CMD_WRITE:
                    ack_width = `RDP_ACK_WRITE;
                `RDP_CMD_ALL1:
                    ack_width = b19 ? `RDP_ACK_RCV : `RDP_ACK_NONE;
                default:
                    ack_width = `RDP_ACK_NONE;
            endcase
        end
    endfunction

    // word-aligned form of a 16-bit byte address
    function [15:0] word_addr;
        input [15:0] a;
        begin
            word_addr = a & `RDP_WORD_MASK;
        end
    endfunction

    wire [1:0] sync_q;
    wire sclk_q = sync_q[1];
    wire sin_q = sync_q[0];
    reg sclk_prev_reg;
    reg [4:0] bitcnt_reg;
    reg [31:0] rx_reg;
    reg [6:0] ones_reg;
    reg [31:0] tx_word_reg;
    reg [2:0] ack_cnt_reg;
    reg [15:0] cpu_addr_reg;
    reg [31:0] resp_reg;
    reg [31:0] resp2_reg;
    reg resp2_valid_reg;
    reg data_wait_reg;
    reg wr_ok_reg;
    reg wr_armed_reg;
    reg [1:0] wr_frames_reg;
    reg [15:0] wr_addr_reg;
    reg [31:0] wr_data_reg;
    reg eng_write_seq_reg;
    wire [31:0] eng_pre;
    wire [31:0] eng_post;
    wire eng_done;
    wire eng_busy;

    // both link pins cross into CLK through two flops
    rdp_sync #(
        .W(2)
    ) u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d({DBG_SHIFT_CLOCK, DBG_SERIAL_IN}),
        .q(sync_q)
    );

    // edges of the host clock, seen in CLK
    wire sclk_rise = sclk_q & ~sclk_prev_reg;
    wire sclk_fall = ~sclk_q & sclk_prev_reg;
    // lsb first, new bit enters at the top
    wire [31:0] frame_word = {sin_q, rx_reg[`RDP_FRAME_MSB:1]};
    // 64 ones in a row, whatever the framing, means recover
    wire recover = sclk_rise & sin_q & (ones_reg == (`RDP_RCV_ONES - 7'h01));
    wire frame_done = sclk_rise & (bitcnt_reg == `RDP_LAST_BIT) & ~recover;

    // command field of the finished frame
    // only bits 16 to 18 kept as the command
    wire [2:0] cmd = frame_word[`RDP_CMD_MSB:`RDP_CMD_LSB];
    wire cmd_b19 = frame_word[`RDP_RCV_BIT];
    wire [15:0] cmd_addr = word_addr(frame_word[`RDP_ADDR_MSB:0]);
    // host addresses below the RAM window are never used
    wire addr_ok = (cmd_addr >= `RDP_RAM_LO);
    // memory commands are dropped while a write sequence owns the engine
    // post-write word must not be overwritten
    wire eng_free = ~eng_busy & ~wr_armed_reg & ~data_wait_reg & ~resp2_valid_reg;

    reg eng_start;
    reg eng_write;
    reg [15:0] eng_addr;
    reg irq_fire;

    // decide which RAM access a finished frame launches
    always @*
    begin
        eng_start = 1'b0;
        eng_write = 1'b0;
        eng_addr = word_addr(cpu_addr_reg);
        irq_fire = 1'b0;
        if (frame_done && wr_armed_reg && (wr_frames_reg == `RDP_WR_LAG))
        begin
            // write launched as the third frame after data begins
            eng_start = wr_ok_reg;
            eng_write = 1'b1;
            eng_addr = wr_addr_reg;
        end
        else if (frame_done && !data_wait_reg)
        begin
            case (cmd)
                // monitor reads the last CPU address
                `RDP_CMD_MON0, `RDP_CMD_MON1, `RDP_CMD_MON2:
                    eng_start = eng_free;
                `RDP_CMD_IRQ:
                begin
                    eng_start = eng_free;
                    irq_fire = 1'b1;
                end
                `RDP_CMD_READ:
                begin
                    eng_start = eng_free & addr_ok;
                    eng_addr = cmd_addr;
                end
                default:
                    eng_start = 1'b0;
            endcase
        end
    end

    // serial front end: bit count, receive shift, ones run
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sclk_prev_reg <= 1'b1;
            bitcnt_reg <= 5'h00;
            rx_reg <= 32'h00000000;
            ones_reg <= 7'h00;
        end
        else
        begin
            sclk_prev_reg <= sclk_q;
            // host data sampled on rising edges
            if (sclk_rise)
            begin
                rx_reg <= frame_word;
                // recovery realigns the frame counter too
                bitcnt_reg <= recover ? 5'h00 : bitcnt_reg + 5'h01;
                if (!sin_q)
                    ones_reg <= 7'h00;
                else if (ones_reg != `RDP_RCV_ONES)
                    ones_reg <= ones_reg + 7'h01;
            end
        end
    end

    // transmit and acknowledge pins
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            DBG_SERIAL_OUT <= 1'b1;
            DBG_ACK_PULSE <= 1'b1;
            tx_word_reg <= `RDP_IDLE_WORD;
            ack_cnt_reg <= 3'h0;
        end
        else if (recover)
        begin
            DBG_SERIAL_OUT <= 1'b1;
            DBG_ACK_PULSE <= 1'b0;
            tx_word_reg <= `RDP_IDLE_WORD;
            ack_cnt_reg <= `RDP_ACK_RCV;
        end
        else if (frame_done)
        begin
            // one whole word per output frame
            tx_word_reg <= resp_reg;
            DBG_SERIAL_OUT <= resp_reg[0];
            // ack low once a frame is taken, stays high for codes with no ack width
            // width from command, data frame counts as write
            ack_cnt_reg <= data_wait_reg ? `RDP_ACK_WRITE : ack_width(cmd, cmd_b19);
            DBG_ACK_PULSE <= data_wait_reg ? 1'b0 :
                (ack_width(cmd, cmd_b19) == `RDP_ACK_NONE);
        end
        else
        begin
            // later bits change on falling edges
            if (sclk_fall && (bitcnt_reg != 5'h00))
                DBG_SERIAL_OUT <= tx_word_reg[bitcnt_reg];
            // ack released after its count of rising edges
            if (sclk_rise && (ack_cnt_reg != 3'h0))
            begin
                ack_cnt_reg <= ack_cnt_reg - 3'h1;
                if (ack_cnt_reg == 3'h1)
                    DBG_ACK_PULSE <= 1'b1;
            end
        end
    end

    // write pipeline: address frame, data frame, lag frames
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            data_wait_reg <= 1'b0;
            wr_ok_reg <= 1'b0;
            wr_armed_reg <= 1'b0;
            wr_frames_reg <= 2'h0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= 32'h00000000;
        end
        else if (recover)
        begin
            data_wait_reg <= 1'b0;
            wr_armed_reg <= 1'b0;
        end
        else if (frame_done)
        begin
            if (data_wait_reg)
            begin
                // frame after the command is write data
                wr_data_reg <= frame_word;
                data_wait_reg <= 1'b0;
                wr_armed_reg <= 1'b1;
                wr_frames_reg <= 2'h0;
            end
            else if (wr_armed_reg)
            begin
                if (wr_frames_reg == `RDP_WR_LAG)
                    wr_armed_reg <= 1'b0;
                else
                    wr_frames_reg <= wr_frames_reg + 2'h1;
            end
            else if (cmd == `RDP_CMD_WRITE)
            begin
                // bad address still swallows its data frame
                data_wait_reg <= 1'b1;
                wr_ok_reg <= addr_ok & ~eng_busy;
                wr_addr_reg <= cmd_addr;
            end
        end
    end

    // response words, last CPU address and interrupt pulse
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            resp_reg <= `RDP_IDLE_WORD;
            resp2_reg <= `RDP_IDLE_WORD;
            resp2_valid_reg <= 1'b0;
            eng_write_seq_reg <= 1'b0;
            cpu_addr_reg <= `RDP_RAM_LO;
            DBG_IRQ <= 1'b0;
        end
        else
        begin
            DBG_IRQ <= irq_fire;
            if (CPU_ACC_VALID)
                cpu_addr_reg <= CPU_ACC_ADDR;
            if (eng_start)
                eng_write_seq_reg <= eng_write;
            if (recover)
            begin
                resp_reg <= `RDP_IDLE_WORD;
                resp2_valid_reg <= 1'b0;
            end
            else if (eng_done)
            begin
                // pre-write word first, post-write word next
                resp_reg <= eng_pre;
                resp2_reg <= eng_post;
                resp2_valid_reg <= eng_write_seq_reg;
            end
            else if (frame_done && resp2_valid_reg)
            begin
                resp_reg <= resp2_reg;
                resp2_valid_reg <= 1'b0;
            end
        end
    end

    // RAM path runs beside the CPU, never stalls it
    rdp_ram_engine u_engine (
        .clk(CLK),
        .rst_b(RST_B),
        .clear(recover),
        .start(eng_start),
        .do_write(eng_write),
        .addr(eng_addr),
        .wdata(wr_data_reg),
        .cpu_next(CPU_RAM_NEXT),
        .ram_rdata(RAM_RDATA),
        .ram_en(RAM_EN),
        .ram_we(RAM_WE),
        .ram_addr(RAM_ADDR),
        .ram_wdata(RAM_WDATA),
        .pre_data(eng_pre),
        .post_data(eng_post),
        .done(eng_done),
        .busy(eng_busy)
    );
endmodule // rdp_top

// ==== tb/rdp_monitor.sv ====
// pin-level assertion checker for the realtime debug port
`timescale 1ns/1ps
module rdp_monitor (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // link and cpu pins
    input wire DBG_SERIAL_OUT,
    input wire DBG_ACK_PULSE,
    input wire DBG_IRQ,
    input wire CPU_RAM_NEXT,
    // dedicated ram port
    input wire RAM_EN,
    input wire RAM_WE,
    input wire [15:0] RAM_ADDR
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    logic [7:0] rd_age_reg;
    // cycles since the last plain read; saturates so a lone write fails
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            rd_age_reg <= 8'hff;
        else if (RAM_EN && !RAM_WE)
            rd_age_reg <= 8'h00;
        else if (rd_age_reg != 8'hff)
            rd_age_reg <= rd_age_reg + 8'h01;
    end
    sequence wr_s;
        RAM_EN && RAM_WE;
    endsequence
    sequence rd_s;
        RAM_EN && !RAM_WE;
    endsequence
    reset_idle_a:
        assert property ($rose(RST_B) |-> DBG_SERIAL_OUT && DBG_ACK_PULSE && !DBG_IRQ)
        else $error("outputs not idle after reset");
    word_align_a:
        assert property (RAM_EN |-> RAM_ADDR[1:0] == 2'h0)
        else $error("ram access not word aligned");
    cpu_free_a:
        assert property (RAM_EN |-> !$past(CPU_RAM_NEXT))
        else $error("ram access in a cpu cycle");
    ram_range_a:
        assert property (RAM_EN |-> RAM_ADDR >= 16'h4000)
        else $error("ram access below ram area");
    one_write_a:
        assert property (wr_s |=> !RAM_WE)
        else $error("write longer than one word");
    pre_read_a:
        assert property (wr_s |-> rd_age_reg < 8'h28)
        else $error("write without read before");
    post_read_a:
        assert property (wr_s |=> ##[0:40] rd_s)
        else $error("write without read after");
    irq_pulse_a:
        assert property ($rose(DBG_IRQ) |=> !DBG_IRQ)
        else $error("irq pulse too long");
    write_seen_c: cover property (wr_s);
endmodule // rdp_monitor

// ==== tb/rdp_host.sv ====
// debug host model: makes the shift clock and swaps 32-bit frames
`timescale 1ns/1ps
module rdp_host (
    // link pins
    output logic sck,
    output logic sdi,
    input wire logic sdo,
    input wire logic ack
);
    logic [31:0] rx_word;
    int ack_w;
    event frame_done;
    // clock idles high and stands still between frames
    initial
    begin
        sck = 1'b1;
        sdi = 1'b1;
    end
    // data set at falling edge, lsb first
    task automatic shift(input logic [31:0] tx, input int nbits);
        logic [31:0] rx;
        int n;
        begin
            n = 0;
            for (int i = 0; i < nbits; i++)
            begin
                sck = 1'b0;
                sdi = tx[i];
                #80;
                sck = 1'b1;
                rx[i] = sdo;
                if (ack === 1'b0)
                    n++;
                #80;
            end
            // released line shows the inverse, never a stale copy
            sdi = ~sdi;
            rx_word = rx;
            ack_w = n;
            if (nbits == 32)
                -> frame_done;
        end
    endtask
endmodule // rdp_host

// ==== tb/rdp_top_tb_top.sv ====
// self-checking bench for the realtime debug port
`timescale 1ns/1ps
module rdp_top_tb_top;
    typedef struct {bit c; logic [31:0] v;} rdp_note_t;
    logic clk, rst_b, cpu_ram_next = 1'b0, cpu_acc_valid;
    logic [3:0] mon_codes [7] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'hc, 4'hd, 4'h6};
    logic [15:0] cpu_acc_addr, a;
    logic [31:0] ram_rdata = 32'h0, old, nw;
    logic [31:0] mem [0:16383];
    wire sck, sdi, sdo, ack, irq, ram_en, ram_we;
    wire [15:0] ram_addr;
    wire [31:0] ram_wdata;
    rdp_note_t ack_q[$], dat_q[$];
    int error_cnt = 0, checked = 0, nf = 0, n_ram = 0, n_irq = 0, cyc = 0, r0;
    rdp_top uut (.CLK(clk), .RST_B(rst_b), .DBG_SHIFT_CLOCK(sck), .DBG_SERIAL_IN(sdi),
        .DBG_SERIAL_OUT(sdo), .DBG_ACK_PULSE(ack), .DBG_IRQ(irq),
        .CPU_RAM_NEXT(cpu_ram_next), .CPU_ACC_VALID(cpu_acc_valid),
        .CPU_ACC_ADDR(cpu_acc_addr), .RAM_EN(ram_en), .RAM_WE(ram_we),
        .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .RAM_RDATA(ram_rdata));
    rdp_host host (.sck(sck), .sdi(sdi), .sdo(sdo), .ack(ack));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // synchronous ram; bus scrambles when no read is due
    always @(posedge clk)
    begin
        if (ram_en && ram_we)
            mem[ram_addr[15:2]] <= ram_wdata;
        ram_rdata <= ram_en ? mem[ram_addr[15:2]] : ~ram_rdata;
        n_ram <= n_ram + 32'(ram_en);
        n_irq <= n_irq + 32'(irq);
        cpu_ram_next <= ($urandom % 3) == 0;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    // command in bits 16..19, upper bits kept all ones
    function automatic logic [31:0] cmd(input logic [3:0] c, input logic [15:0] ad);
        return {12'hfff, c, ad};
    endfunction
    // notes the expected ack width and response word, then sends
    task automatic frame(input logic [31:0] tx, input bit ca, input int ea, input bit cd,
        input logic [31:0] ed);
        ack_q.push_back('{ca, 32'(ea)});
        dat_q.push_back('{cd, ed});
        host.shift(tx, 32);
    endtask
    task automatic cpu_touch(input logic [15:0] ad);
        @(posedge clk);
        cpu_acc_valid <= 1'b1;
        cpu_acc_addr <= ad;
        @(posedge clk);
        cpu_acc_valid <= 1'b0;
    endtask
    // host addresses stay inside the ram window
    function automatic logic [15:0] rnd_addr();
        return 16'h4000 + 16'($urandom % 32'hc000);
    endfunction
    // ack of frame n-1 and word of frame n-2 arrive with frame n
    always @(host.frame_done)
    begin
        rdp_note_t n;
        nf++;
        if (nf >= 2)
        begin
            n = ack_q.pop_front();
            if (n.c)
                cmp("ack width", n.v, 32'(host.ack_w));
        end
        if (nf >= 3)
        begin
            n = dat_q.pop_front();
            if (n.c)
                cmp("response", n.v, host.rx_word);
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        rst_b = 1'b0;
        cpu_acc_valid = 1'b0;
        cpu_acc_addr = 16'h4000;
        void'($urandom(68));
        for (int i = 0; i < 16384; i++)
            mem[i] = $urandom;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        cmp("idle out", 32'h1, 32'(sdo));
        cmp("idle ack", 32'h1, 32'(ack));
        // back-to-back reads, unaligned low bits, top word
        for (int i = 0; i < 5; i++)
        begin
            a = (i == 4) ? 16'hffff : rnd_addr();
            frame(cmd(4'h2, a), 1, 2, 1, mem[a[15:2]]);
        end
        $display("test reads done");
        // every monitor code, with and without bit 19, then irq
        foreach (mon_codes[i])
        begin
            a = rnd_addr() & 16'hfffc;
            cpu_touch(a);
            r0 = n_irq;
            frame(cmd(mon_codes[i], rnd_addr()), 1, 1, 1, mem[a[15:2]]);
        end
        // clock stopped after a frame: ack still low
        repeat (10) @(posedge clk);
        cmp("ack held", 32'h0, 32'(ack));
        cmp("irq count", r0 + 1, n_irq);
        $display("test monitor done");
        // write with verify: old word then new word come back
        a = rnd_addr();
        old = mem[a[15:2]];
        nw = $urandom;
        frame(cmd(4'h3, a), 1, 3, 0, 0);
        frame(nw, 1, 3, 0, 0);
        frame(cmd(4'h0, a), 1, 1, 0, 0);
        frame(cmd(4'h0, a), 1, 1, 1, old);
        frame(cmd(4'h0, a), 1, 1, 1, nw);
        cmp("ram word", nw, mem[a[15:2]]);
        $display("test write done");
        // reserved code and out-of-range read touch nothing
        repeat (20) @(posedge clk);
        r0 = n_ram;
        frame(cmd(4'h1, 16'h5000), 1, 0, 0, 0);
        frame(cmd(4'h2, 16'h3ffc), 0, 0, 0, 0);
        repeat (20) @(posedge clk);
        cmp("ram accesses", r0, n_ram);
        $display("test refusal done");
        // runaway: stray bits, then two all-ones frames recover
        frame(cmd(4'h0, 16'h4000), 0, 0, 0, 0);
        // stray zeros knock the framing out of step before the ones run
        host.shift(32'h00000000, 8);
        frame(32'hffffffff, 0, 0, 0, 0);
        frame(32'hffffffff, 1, 4, 0, 0);
        a = rnd_addr();
        frame(cmd(4'h2, a), 1, 2, 1, mem[a[15:2]]);
        frame(cmd(4'h0, a), 0, 0, 0, 0);
        frame(cmd(4'h0, a), 0, 0, 0, 0);
        $display("test recover done");
        final_report();
    end
endmodule // rdp_top_tb_top
bind rdp_top rdp_monitor mon (.CLK(CLK), .RST_B(RST_B), .DBG_SERIAL_OUT(DBG_SERIAL_OUT),
    .DBG_ACK_PULSE(DBG_ACK_PULSE), .DBG_IRQ(DBG_IRQ), .CPU_RAM_NEXT(CPU_RAM_NEXT),
    .RAM_EN(RAM_EN), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR));
